// ===== include/svw_pkg.sv
/*
 Shared constants, types and timing helpers of the supervisor watchdog.
 Assumes a 100 MHz system clock and a 6.55 kHz nominal timebase.
*/
package svw_pkg;
  localparam int CNT_W = 16;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 6550;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int WD_SHORT_MS = 100;
  localparam int WD_LONG_MS = 1600;
  localparam int RST_MS = 50;
  localparam int RST_LONG_MS = 200;

  typedef logic [CNT_W-1:0] svw_cnt_t;

  localparam svw_cnt_t WD_SHORT_TICKS = svw_cnt_t'(WD_SHORT_MS * OSC_HZ / 1000);
  localparam svw_cnt_t WD_LONG_TICKS = svw_cnt_t'(WD_LONG_MS * OSC_HZ / 1000);
  localparam svw_cnt_t RST_TICKS = svw_cnt_t'(RST_MS * OSC_HZ / 1000);
  localparam svw_cnt_t RST_LONG_TICKS = svw_cnt_t'(RST_LONG_MS * OSC_HZ / 1000);
  localparam svw_cnt_t EXT_WD_NORM_CLKS = 16'h0400;
  localparam svw_cnt_t EXT_WD_AFTER_CLKS = 16'h1000;
  localparam svw_cnt_t EXT_RST_CLKS = 16'h0200;
  localparam svw_cnt_t EXT_RST_LONG_CLKS = 16'h0800;
  localparam svw_cnt_t CNT_ONE = 16'h0001;

  localparam logic CE_OUT_RST = 1'h1;
  localparam logic PFO_RST = 1'h0;
  localparam logic WDO_RST = 1'h1;
  localparam logic RSTN_RST = 1'h0;

  typedef struct packed {
    logic below_reset;
    logic below_batt;
    logic pf_below_ref;
  } svw_supply_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_PULSE = 2'b01,
    ST_RUN = 2'b10
  } svw_state_t;

  function automatic svw_cnt_t wd_period(logic ext, logic short_sel,
                                         logic after);
    if (ext) begin
      return after ? EXT_WD_AFTER_CLKS : EXT_WD_NORM_CLKS;
    end
    return (short_sel && !after) ? WD_SHORT_TICKS : WD_LONG_TICKS;
  endfunction : wd_period

  function automatic svw_cnt_t rst_width(logic ext, logic long_v);
    if (ext) begin
      return long_v ? EXT_RST_LONG_CLKS : EXT_RST_CLKS;
    end
    return long_v ? RST_LONG_TICKS : RST_TICKS;
  endfunction : rst_width
endpackage : svw_pkg

// ===== src/svw_tick_gen.sv
/*
 Timebase tick generator: internal divider or rising edges of an external
 clock pin. Assumes the external pin is synchronous to clk.
*/
`timescale 1ns/100ps
module svw_tick_gen
  import svw_pkg::*;
#(
  parameter int unsigned DIV = OSC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_mode,
  input wire logic timebase_input,
  output logic tick
);
  localparam int DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] div_q, div_d;
  logic pin_q, pin_d;
  logic tick_q, tick_d;

  always_comb begin
    pin_d = timebase_input;
    div_d = div_q;
    tick_d = 1'h0;
    if (ext_mode) begin
      div_d = '0;
      tick_d = timebase_input & ~pin_q;
    end else if (div_q == DIV_LAST) begin
      div_d = '0;
      tick_d = 1'h1;
    end else begin
      div_d = div_q + DW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      pin_q <= 1'h0;
      tick_q <= 1'h0;
    end else begin
      div_q <= div_d;
      pin_q <= pin_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : svw_tick_gen

// ===== src/svw_toggle_edge.sv
/*
 Toggle input synchroniser and both-edge detector.
 Assumes the toggle pin may change at any time relative to clk.
*/
`timescale 1ns/100ps
module svw_toggle_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic toggle_in,
  output logic toggle_edge
);
  logic s1_q, s2_q, s3_q, prime_q, edge_q;
  logic s1_d, s2_d, s3_d, prime_d, edge_d;

  always_comb begin
    s1_d = toggle_in;
    s2_d = s1_q;
    s3_d = s2_q;
    prime_d = 1'h1;
    // First comparison after reset is discarded
    edge_d = prime_q & (s2_q ^ s3_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
      prime_q <= 1'h0;
      edge_q <= 1'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      prime_q <= prime_d;
      edge_q <= edge_d;
    end
  end

  assign toggle_edge = edge_q;
endmodule : svw_toggle_edge

// ===== src/svw_supervisor_top.sv
/*
 Digital core of a processor supervisor: reset generator, watchdog with
 expiry flag, chip-enable gate and power-fail warning.
 Assumes the analog comparators arrive as flags synchronous to clk and
 that floating pins are reported by separate float-detect inputs.
*/
// Summary of operation
// - Supply valid: gated chip enable follows chip-enable input.
// - Supply below reset threshold forces gated chip enable high.
// - Supply below backup level also forces gated chip enable high.
// - Power-fail warning low while sense input is below reference.
// - Below backup level, warning held low, comparator ignored.
// - Missed toggle within timeout produces one reset pulse.
// - Watchdog restarts after each reset pulse with after-reset timeout.
// - Static toggle input repeats a reset every after-reset period.
// - Floating toggle input disables the watchdog entirely.
// - Expiry drives expired flag low until next toggle transition.
// - Supply below reset threshold releases expired flag high.
// - Fixed build: 1.6 s timeout and 50 ms pulse (200 ms with LONG_VARIANT), no selection.
// - Floating source select uses internal oscillator; input sets period.
// - Right after any reset, internal modes time out at 1.6 s.
// - Short period takes effect only after first toggle after reset.
// - External clock: 1024/4096 clocks timeout, 512/2048 clock pulse.
// - Internal timebase runs at nominal 6.55 kHz.
// - Reset held low while supply low, then for reset width.
`timescale 1ns/100ps
module svw_supervisor_top
  import svw_pkg::*;
#(
  parameter int unsigned DIV = OSC_DIV,
  parameter logic LONG_VARIANT = 1'h0,
  parameter logic ADJUSTABLE = 1'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire svw_supply_t supply,
  input wire logic chip_enable_in_n,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_toggle_float,
  input wire logic timebase_source_select,
  input wire logic timebase_source_float,
  input wire logic timebase_input,
  input wire logic timebase_input_float,
  output logic chip_enable_out_n,
  output logic power_fail_warning_out_n,
  output logic watchdog_expired_out_n,
  output logic reset_out_n
);
  logic ext_mode;
  logic short_sel;
  logic wd_disable;
  logic tick;
  logic tog_edge;
  logic wd_expire;

  svw_state_t state_q, state_d;
  svw_cnt_t wd_cnt_q, wd_cnt_d;
  svw_cnt_t rst_cnt_q, rst_cnt_d;
  logic after_q, after_d;
  logic ce_q, ce_d;
  logic pfo_q, pfo_d;
  logic wdo_q, wdo_d;
  logic rstn_q, rstn_d;

  // Timebase selection; fixed build ignores every select pin
  always_comb begin
    ext_mode = ADJUSTABLE & ~timebase_source_float
               & ~timebase_source_select;
    short_sel = ADJUSTABLE & ~ext_mode & ~timebase_input_float
                & ~timebase_input;
    wd_disable = watchdog_toggle_float;
  end

  // Divider from clk gives the internal oscillator tick
  svw_tick_gen #(
    .DIV(DIV)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .ext_mode(ext_mode),
    .timebase_input(timebase_input),
    .tick(tick)
  );

  svw_toggle_edge u_toggle (
    .clk(clk),
    .rst(rst),
    .toggle_in(watchdog_toggle_in),
    .toggle_edge(tog_edge)
  );

  // Reset and watchdog sequencing
  always_comb begin
    state_d = state_q;
    wd_cnt_d = wd_cnt_q;
    rst_cnt_d = rst_cnt_q;
    after_d = after_q;
    wd_expire = 1'h0;
    case (state_q)
      ST_HOLD: begin
        rst_cnt_d = rst_width(ext_mode, LONG_VARIANT);
        if (!supply.below_reset) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (supply.below_reset) begin
          state_d = ST_HOLD;
        end else if (tick) begin
          if (rst_cnt_q <= CNT_ONE) begin
            state_d = ST_RUN;
            after_d = 1'h1;
            wd_cnt_d = wd_period(ext_mode, short_sel, 1'h1);
          end else begin
            rst_cnt_d = rst_cnt_q - CNT_ONE;
          end
        end
      end
      ST_RUN: begin
        if (supply.below_reset) begin
          state_d = ST_HOLD;
        end else if (wd_disable) begin
          // Re-enabling starts a full period
          wd_cnt_d = wd_period(ext_mode, short_sel, after_q);
        end else if (tog_edge) begin
          after_d = 1'h0;
          wd_cnt_d = wd_period(ext_mode, short_sel, 1'h0);
        end else if (tick) begin
          if (wd_cnt_q <= CNT_ONE) begin
            wd_expire = 1'h1;
            state_d = ST_PULSE;
            rst_cnt_d = rst_width(ext_mode, LONG_VARIANT);
          end else begin
            wd_cnt_d = wd_cnt_q - CNT_ONE;
          end
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  // Output next values
  always_comb begin
    if (supply.below_reset || supply.below_batt) begin
      ce_d = 1'h1;
    end else begin
      ce_d = chip_enable_in_n;
    end
    if (supply.below_batt) begin
      pfo_d = 1'h0;
    end else begin
      pfo_d = ~supply.pf_below_ref;
    end
    wdo_d = wdo_q;
    if (supply.below_reset) begin
      wdo_d = 1'h1;
    end else if (wd_expire) begin
      wdo_d = 1'h0;
    end else if (tog_edge) begin
      wdo_d = 1'h1;
    end
    rstn_d = (state_d == ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_HOLD;
      wd_cnt_q <= WD_LONG_TICKS;
      rst_cnt_q <= RST_TICKS;
      after_q <= 1'h1;
      ce_q <= CE_OUT_RST;
      pfo_q <= PFO_RST;
      wdo_q <= WDO_RST;
      rstn_q <= RSTN_RST;
    end else begin
      state_q <= state_d;
      wd_cnt_q <= wd_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      after_q <= after_d;
      ce_q <= ce_d;
      pfo_q <= pfo_d;
      wdo_q <= wdo_d;
      rstn_q <= rstn_d;
    end
  end

  assign chip_enable_out_n = ce_q;
  assign power_fail_warning_out_n = pfo_q;
  assign watchdog_expired_out_n = wdo_q;
  assign reset_out_n = rstn_q;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence expiry_s;
    wd_expire && !supply.below_reset;
  endsequence

  sequence pulse_start_s;
    !reset_out_n && (state_q == ST_PULSE)
      && (rst_cnt_q == rst_width($past(ext_mode), LONG_VARIANT));
  endsequence

  sequence pulse_end_s;
    (state_q == ST_PULSE) && (state_d == ST_RUN);
  endsequence

  sequence rearm_s;
    after_q && reset_out_n
      && (wd_cnt_q == wd_period($past(ext_mode), $past(short_sel), 1'h1));
  endsequence

  ce_pass_a: assert property (
    (!supply.below_reset && !supply.below_batt)
      |=> (chip_enable_out_n == $past(chip_enable_in_n))
  ) else $error("gated chip enable does not follow its input");

  ce_reset_gate_a: assert property (
    supply.below_reset |=> chip_enable_out_n
  ) else $error("chip enable not forced high on low supply");

  ce_batt_gate_a: assert property (
    supply.below_batt |=> chip_enable_out_n
  ) else $error("chip enable not forced high below backup level");

  pfo_warn_a: assert property (
    !supply.below_batt |=> (power_fail_warning_out_n
                            == !$past(supply.pf_below_ref))
  ) else $error("power-fail warning does not track comparator");

  pfo_batt_a: assert property (
    supply.below_batt |=> !power_fail_warning_out_n
  ) else $error("power-fail warning not held low below backup level");

  wd_pulse_a: assert property (
    expiry_s |=> pulse_start_s
  ) else $error("watchdog expiry did not start a reset pulse");

  wd_rearm_a: assert property (
    pulse_end_s and !supply.below_reset |=> rearm_s
  ) else $error("watchdog not reloaded with after-reset period");

  wd_off_a: assert property (
    wd_disable |-> !wd_expire
  ) else $error("watchdog expired while disabled");

  wdo_hold_a: assert property (
    (!watchdog_expired_out_n && !tog_edge && !supply.below_reset)
      |=> !watchdog_expired_out_n
  ) else $error("expired flag released without a toggle");

  wdo_set_a: assert property (
    expiry_s |=> !watchdog_expired_out_n ##1 !reset_out_n
  ) else $error("expiry did not drive the expired flag low");

  wdo_release_a: assert property (
    supply.below_reset |=> watchdog_expired_out_n
  ) else $error("expired flag not released on low supply");

  short_switch_a: assert property (
    (tog_edge && state_q == ST_RUN && !wd_disable && !supply.below_reset)
      |=> !after_q
  ) else $error("after-reset period kept after first toggle");

  rst_hold_a: assert property (
    supply.below_reset |=> !reset_out_n [*2]
  ) else $error("reset output released while supply is low");
endmodule : svw_supervisor_top

// ===== bench/svw_host_model.sv
/*
 Host processor model that services the watchdog toggle pin.
 Assumes the bench changes en and period just after a falling clock edge.
*/
`timescale 1ns/100ps
module svw_host_model (
  input wire logic clk,
  input wire logic en,
  input wire logic [31:0] period,
  output logic toggle_out
);
  int unsigned cnt_q = 0;
  logic want_q = 1'h0;

  // Pin left in its power-up level until the bench enables service
  always @(posedge clk) begin
    if (en) begin
      if (cnt_q + 1 >= period) begin
        cnt_q <= 0;
        want_q <= 1'h1;
      end else begin
        cnt_q <= cnt_q + 1;
        want_q <= 1'h0;
      end
    end else begin
      want_q <= 1'h0;
    end
  end

  initial toggle_out = 1'h0;

  // Pin changes only on the falling edge
  always @(negedge clk) begin
    if (want_q) begin
      toggle_out <= ~toggle_out;
    end
  end
endmodule : svw_host_model

// ===== bench/tb_top.sv
/*
 Self-checking bench of the supervisor top: gating, reset and watchdog.
 Assumes the host model drives the toggle pin; DIV is shortened to 4.
*/
`timescale 1ns/100ps
module tb_top
  import svw_pkg::*;
;
  localparam int DIV_TB = 4;
  localparam int EXT_TOL = 8;
  localparam int INT_TOL = 14;
  localparam int IDLE_SPAN = 10000;
  logic clk = 1'h0;
  logic rst = 1'h1;
  svw_supply_t supply = '0;
  logic ce_in_n = 1'h1;
  logic tog_float = 1'h0;
  logic src_float = 1'h0;
  logic in_float = 1'h0;
  logic tb_in = 1'h0;
  logic tb_run = 1'h1;
  logic host_en = 1'h0;
  int unsigned host_period = 1;
  logic toggle;
  logic ce_out_n;
  logic pfo_n;
  logic wdo_n;
  logic rst_out_n;
  int bad_count = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  // External timebase: one rising edge every two clocks
  always @(negedge clk) tb_in <= tb_run ? ~tb_in : 1'h0;

  svw_host_model host_u (
    .clk(clk),
    .en(host_en),
    .period(host_period),
    .toggle_out(toggle)
  );

  svw_supervisor_top #(
    .DIV(DIV_TB),
    .LONG_VARIANT(1'h0),
    .ADJUSTABLE(1'h1)
  ) dut_u (
    .clk(clk),
    .rst(rst),
    .supply(supply),
    .chip_enable_in_n(ce_in_n),
    .watchdog_toggle_in(toggle),
    .watchdog_toggle_float(tog_float),
    .timebase_source_select(1'h0),
    .timebase_source_float(src_float),
    .timebase_input(tb_in),
    .timebase_input_float(in_float),
    .chip_enable_out_n(ce_out_n),
    .power_fail_warning_out_n(pfo_n),
    .watchdog_expired_out_n(wdo_n),
    .reset_out_n(rst_out_n)
  );

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_near(input int got, input int exp, input int tol);
    n_tests++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_near

  task automatic wait_rst(input logic v, input int lim, output int n);
    n = 0;
    while (rst_out_n !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_rst

  // One toggle of the host pin
  task automatic kick();
    host_period = 1;
    host_en = 1'h1;
    @(negedge clk);
    host_en = 1'h0;
  endtask : kick

  task automatic t_gate();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      supply = svw_supply_t'(v[3:1]);
      ce_in_n = v[0];
      @(negedge clk);
      check_val(ce_out_n, (v[3] | v[2]) ? 1'h1 : v[0]);
      check_val(pfo_n, v[2] ? 1'h0 : !v[1]);
    end
    supply = '0;
  endtask : t_gate

  task automatic t_ext();
    int n;
    wait_rst(1'h1, 4000, n);
    check_near(n, 2 * int'(EXT_RST_CLKS), EXT_TOL);
    wait_rst(1'h0, 20000, n);
    check_near(n, 2 * int'(EXT_WD_AFTER_CLKS), EXT_TOL);
    check_val(wdo_n, 1'h0);
    wait_rst(1'h1, 4000, n);
    check_near(n, 2 * int'(EXT_RST_CLKS), EXT_TOL);
    wait_rst(1'h0, 20000, n);
    check_near(n, 2 * int'(EXT_WD_AFTER_CLKS), EXT_TOL);
    wait_rst(1'h1, 4000, n);
    check_near(n, 2 * int'(EXT_RST_CLKS), EXT_TOL);
    kick();
    repeat (5) @(negedge clk);
    check_val(wdo_n, 1'h1);
    wait_rst(1'h0, 20000, n);
    check_near(n, 2 * int'(EXT_WD_NORM_CLKS), EXT_TOL);
    check_val(wdo_n, 1'h0);
    supply.below_reset = 1'h1;
    repeat (2) @(negedge clk);
    check_val(wdo_n, 1'h1);
    repeat (50) @(negedge clk);
    check_val(rst_out_n, 1'h0);
    supply.below_reset = 1'h0;
    wait_rst(1'h1, 4000, n);
    check_near(n, 2 * int'(EXT_RST_CLKS), EXT_TOL);
  endtask : t_ext

  task automatic t_disable();
    int n;
    tog_float = 1'h1;
    wait_rst(1'h0, IDLE_SPAN, n);
    check_val(n, IDLE_SPAN);
    tog_float = 1'h0;
  endtask : t_disable

  task automatic t_int();
    int n;
    tb_run = 1'h0;
    src_float = 1'h1;
    supply.below_reset = 1'h1;
    repeat (3) @(negedge clk);
    supply.below_reset = 1'h0;
    wait_rst(1'h1, 2000, n);
    check_near(n, DIV_TB * int'(RST_TICKS), INT_TOL);
    wait_rst(1'h0, 50000, n);
    check_near(n, DIV_TB * int'(WD_LONG_TICKS), INT_TOL);
    wait_rst(1'h1, 2000, n);
    check_near(n, DIV_TB * int'(RST_TICKS), INT_TOL);
    kick();
    wait_rst(1'h0, 5000, n);
    check_near(n, DIV_TB * int'(WD_SHORT_TICKS), INT_TOL);
    // Floating timebase input keeps the long period after service
    in_float = 1'h1;
    wait_rst(1'h1, 2000, n);
    check_near(n, DIV_TB * int'(RST_TICKS), INT_TOL);
    kick();
    wait_rst(1'h0, 4000, n);
    check_val(n, 4000);
  endtask : t_int

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_gate();
    t_ext();
    t_disable();
    t_int();
    print_verdict();
  end

  // Expected run is about 85k cycles
  initial begin
    repeat (95000) @(negedge clk);
    bad_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
    print_verdict();
  end
endmodule : tb_top
